//--- verilog/ldcr_defines.svh
// offsets, field positions, reset values and write masks of the logical device configuration bank
`ifndef LDCR_DEFINES_SVH
`define LDCR_DEFINES_SVH

// ----------------------------------------
// logical device numbers (upper address byte)
// ----------------------------------------
`define LDCR_LDN_FLOPPY        8'h00
`define LDCR_LDN_PARALLEL      8'h03
`define LDCR_LDN_SERIAL_ONE    8'h04

// ----------------------------------------
// register indices (lower address byte)
// ----------------------------------------
`define LDCR_IDX_PP_MODE       8'hf0
`define LDCR_IDX_SP1_MODE      8'hf0
`define LDCR_IDX_PP_SHADOW     8'hf1
`define LDCR_IDX_DRV0          8'hf4
`define LDCR_IDX_DRV1          8'hf5

// ----------------------------------------
// reset values
// ----------------------------------------
`define LDCR_RST_PP_MODE       8'h3c
`define LDCR_RST_SP1_MODE      8'h00
`define LDCR_RST_PP_SHADOW     8'h00
`define LDCR_RST_FDD           8'h00

// ----------------------------------------
// bits that store a value; all others read zero
// ----------------------------------------
`define LDCR_WMASK_PP_MODE     8'hff
`define LDCR_WMASK_SP1_MODE    8'h03
`define LDCR_WMASK_PP_SHADOW   8'hbf
`define LDCR_WMASK_FDD         8'h5b

// ----------------------------------------
// field positions
// ----------------------------------------
`define LDCR_FDD_TYPE_LSB      0
`define LDCR_FDD_RATE_LSB      3
`define LDCR_FDD_PRECOMP_OFF   6
`define LDCR_PP_MODE_LSB       0
`define LDCR_PP_THRESH_LSB     3
`define LDCR_PP_IRQ_PULSE      7
`define LDCR_SH_DMA_LSB        0
`define LDCR_SH_IRQ_LSB        3
`define LDCR_SH_TMO_POLICY     7
`define LDCR_SP1_MIDI          0
`define LDCR_SP1_HSPEED        1

`endif

//--- verilog/ldcr_pkg.sv
// types shared by the logical device configuration bank
package ldcr_pkg;

	typedef enum logic [2:0] {
		LDCR_PP_SPP       = 3'b000,
		LDCR_PP_EPP19_SPP = 3'b001,
		LDCR_PP_ECP       = 3'b010,
		LDCR_PP_ECP_EPP19 = 3'b011,
		LDCR_PP_PRINTER   = 3'b100,
		LDCR_PP_EPP17_SPP = 3'b101,
		LDCR_PP_RSVD      = 3'b110,
		LDCR_PP_ECP_EPP17 = 3'b111
	} ldcr_pp_mode_e;

	typedef struct packed {
		logic [1:0] drive_type_select;
		logic [1:0] rate_table_select;
		logic       precomp_enable;
	} ldcr_drive_cfg_s;

	typedef struct packed {
		ldcr_pp_mode_e mode;
		logic [3:0]    fifo_threshold;
		logic          irq_pulsed;
		logic [2:0]    dma_select;
		logic [2:0]    irq_select;
		logic          timeout_by_write;
	} ldcr_pp_cfg_s;

	typedef struct packed {
		logic midi_enable;
		logic high_speed;
	} ldcr_sp1_cfg_s;

endpackage

//--- verilog/ldcr_config_bank.sv
// logical device configuration bank: floppy, parallel port and serial port one options
//
// Summary of operation
// R1 - first drive options: type select bits 1:0
// R2 - bits 4:3 select data rate table
// R3 - drive options bits 2,5,7 read zero
// R4 - bit 6 set disables write precompensation
// R5 - second drive options at next index
// R6 - parallel mode bits 2:0 pick port mode
// R7 - bits 6:3 hold FIFO threshold, default 0111
// R8 - interrupt type: pulse low or follow acknowledge
// R9 - interrupt type ignored in printer/standard modes
// R10 - shadow bits 2:0 select DMA channel
// R11 - shadow bits 5:3 route parallel interrupt
// R12 - shadow bit 6 ignores writes, reads zero
// R13 - policy zero: timeout clears after status read
// R14 - policy one: timeout clears on written one
// R15 - config-B readback hides policy, shows DMA/IRQ
// R16 - serial bit 0 enables MIDI
// R17 - serial bit 1 enables high speed
// R18 - host writes zero to serial bits 6:2
// R19 - only hard reset restores defaults
// R20 - read-only and reserved bits ignore writes
`timescale 1ns/1ps
`include "ldcr_defines.svh"

module ldcr_config_bank (
	// clock and hard reset
	input  wire logic                   clk,
	input  wire logic                   rstn,
	// register port: {logical device, index}
	input  wire logic [15:0]            addr,
	input  wire logic [7:0]             wdata,
	input  wire logic                   wr,
	input  wire logic                   rd,
	output logic      [7:0]             rdata,
	// decoded configuration
	output ldcr_pkg::ldcr_drive_cfg_s   first_drive_options,
	output ldcr_pkg::ldcr_drive_cfg_s   second_drive_options,
	output ldcr_pkg::ldcr_pp_cfg_s      pp_cfg,
	output ldcr_pkg::ldcr_sp1_cfg_s     sp1_cfg,
	output logic      [7:0]             port_config_b_readback,
	// parallel port interrupt pin
	input  wire logic                   ack_n,
	input  wire logic                   pp_irq_event,
	output logic                        pp_irq_out,
	output logic                        pp_irq_oe_n,
	// epp status timeout flag
	input  wire logic                   epp_timeout_set,
	input  wire logic                   epp_status_read_done,
	input  wire logic                   epp_timeout_write_one,
	output logic                        epp_timeout
);

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [7:0] drv0_r;
	logic [7:0] drv1_r;
	logic [7:0] ppm_r;
	logic [7:0] shd_r;
	logic [7:0] sp1_r;
	logic [7:0] rdata_r, rdata_nxt;
	logic       we_drv0;
	logic       we_drv1;
	logic       we_ppm;
	logic       we_shd;
	logic       we_sp1;

	logic [7:0] ldn;
	logic [7:0] idx;
	logic       hit_drv0;
	logic       hit_drv1;
	logic       hit_ppm;
	logic       hit_shd;
	logic       hit_sp1;

	assign ldn      = addr[15:8];
	assign idx      = addr[7:0];

	// one flag per mapped {logical device, index} pair
	always_comb begin
		hit_drv0 = 1'b0;
		hit_drv1 = 1'b0;
		hit_ppm  = 1'b0;
		hit_shd  = 1'b0;
		hit_sp1  = 1'b0;
		case (ldn)
			`LDCR_LDN_FLOPPY: begin
				hit_drv0 = (idx == `LDCR_IDX_DRV0);
				hit_drv1 = (idx == `LDCR_IDX_DRV1); // R5
			end
			`LDCR_LDN_PARALLEL: begin
				hit_ppm = (idx == `LDCR_IDX_PP_MODE);
				hit_shd = (idx == `LDCR_IDX_PP_SHADOW);
			end
			`LDCR_LDN_SERIAL_ONE: begin
				hit_sp1 = (idx == `LDCR_IDX_SP1_MODE);
			end
			default: begin
				// other logical devices own no register in this bank
			end
		endcase
	end

	assign we_drv0 = wr && hit_drv0;
	assign we_drv1 = wr && hit_drv1;
	assign we_ppm  = wr && hit_ppm;
	assign we_shd  = wr && hit_shd;
	assign we_sp1  = wr && hit_sp1;

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	ldcr_cfg_reg #(
		.WIDTH (8),
		.RESET (`LDCR_RST_FDD), // R19
		.WMASK (`LDCR_WMASK_FDD) // R1 R2 R3 R4 R20
	) u_drv0 (
		.clk   (clk),
		.rstn  (rstn),
		.we    (we_drv0),
		.wdata (wdata),
		.q     (drv0_r)
	);

	ldcr_cfg_reg #(
		.WIDTH (8),
		.RESET (`LDCR_RST_FDD), // R5
		.WMASK (`LDCR_WMASK_FDD) // R5 R3 R20
	) u_drv1 (
		.clk   (clk),
		.rstn  (rstn),
		.we    (we_drv1),
		.wdata (wdata),
		.q     (drv1_r)
	);

	ldcr_cfg_reg #(
		.WIDTH (8),
		.RESET (`LDCR_RST_PP_MODE), // R7
		.WMASK (`LDCR_WMASK_PP_MODE) // R6 R7
	) u_ppm (
		.clk   (clk),
		.rstn  (rstn),
		.we    (we_ppm),
		.wdata (wdata),
		.q     (ppm_r)
	);

	ldcr_cfg_reg #(
		.WIDTH (8),
		.RESET (`LDCR_RST_PP_SHADOW),
		.WMASK (`LDCR_WMASK_PP_SHADOW) // R10 R11 R12
	) u_shd (
		.clk   (clk),
		.rstn  (rstn),
		.we    (we_shd),
		.wdata (wdata),
		.q     (shd_r)
	);

	ldcr_cfg_reg #(
		.WIDTH (8),
		.RESET (`LDCR_RST_SP1_MODE),
		.WMASK (`LDCR_WMASK_SP1_MODE) // R16 R17 R20
	) u_sp1 (
		.clk   (clk),
		.rstn  (rstn),
		.we    (we_sp1),
		.wdata (wdata),
		.q     (sp1_r)
	);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb begin
		rdata_nxt = 8'h00;
		// unmapped addresses read zero
		if (rd) begin
			if (hit_drv0)
				rdata_nxt = drv0_r;
			else if (hit_drv1)
				rdata_nxt = drv1_r;
			else if (hit_ppm)
				rdata_nxt = ppm_r;
			else if (hit_shd)
				rdata_nxt = shd_r;
			else if (hit_sp1)
				rdata_nxt = sp1_r;
			else
				rdata_nxt = 8'h00;
		end
	end

	// read data stands one cycle, then drops back to zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rdata_r <= 8'h00;
		else
			rdata_r <= rdata_nxt;
	end

	assign rdata = rdata_r;

	// ----------------------------------------
	// decoded configuration
	// ----------------------------------------
	assign first_drive_options.drive_type_select  = drv0_r[`LDCR_FDD_TYPE_LSB +: 2]; // R1
	assign first_drive_options.rate_table_select  = drv0_r[`LDCR_FDD_RATE_LSB +: 2]; // R2
	assign first_drive_options.precomp_enable     = ~drv0_r[`LDCR_FDD_PRECOMP_OFF]; // R4
	assign second_drive_options.drive_type_select = drv1_r[`LDCR_FDD_TYPE_LSB +: 2]; // R5
	assign second_drive_options.rate_table_select = drv1_r[`LDCR_FDD_RATE_LSB +: 2];
	assign second_drive_options.precomp_enable    = ~drv1_r[`LDCR_FDD_PRECOMP_OFF];

	assign pp_cfg.mode             = ldcr_pkg::ldcr_pp_mode_e'(ppm_r[`LDCR_PP_MODE_LSB +: 3]); // R6
	assign pp_cfg.fifo_threshold   = ppm_r[`LDCR_PP_THRESH_LSB +: 4]; // R7
	assign pp_cfg.irq_pulsed       = ppm_r[`LDCR_PP_IRQ_PULSE];
	assign pp_cfg.dma_select       = shd_r[`LDCR_SH_DMA_LSB +: 3]; // R10
	assign pp_cfg.irq_select       = shd_r[`LDCR_SH_IRQ_LSB +: 3]; // R11
	assign pp_cfg.timeout_by_write = shd_r[`LDCR_SH_TMO_POLICY];

	assign sp1_cfg.midi_enable = sp1_r[`LDCR_SP1_MIDI]; // R16
	assign sp1_cfg.high_speed  = sp1_r[`LDCR_SP1_HSPEED]; // R17

	// policy bit and reserved bit 6 never show in the readback
	assign port_config_b_readback = {2'b00, shd_r[`LDCR_SH_IRQ_LSB +: 3], shd_r[`LDCR_SH_DMA_LSB +: 3]}; // R15

	// ----------------------------------------
	// parallel port interrupt pin
	// ----------------------------------------
	logic irq_out_r, irq_out_nxt;
	logic irq_oe_n_r, irq_oe_n_nxt;
	logic basic_mode;
	logic pulse_style;

	// only printer and standard modes ignore the type bit; reserved 110 honours it
	always_comb begin
		case (pp_cfg.mode)
			ldcr_pkg::LDCR_PP_PRINTER:   basic_mode = 1'b1; // R9
			ldcr_pkg::LDCR_PP_SPP:       basic_mode = 1'b1; // R9
			ldcr_pkg::LDCR_PP_EPP19_SPP: basic_mode = 1'b0;
			ldcr_pkg::LDCR_PP_ECP:       basic_mode = 1'b0;
			ldcr_pkg::LDCR_PP_ECP_EPP19: basic_mode = 1'b0;
			ldcr_pkg::LDCR_PP_EPP17_SPP: basic_mode = 1'b0;
			ldcr_pkg::LDCR_PP_RSVD:      basic_mode = 1'b0;
			ldcr_pkg::LDCR_PP_ECP_EPP17: basic_mode = 1'b0;
			default:                     basic_mode = 1'b0;
		endcase
	end

	assign pulse_style = pp_cfg.irq_pulsed && !basic_mode; // R9

	always_comb begin
		irq_out_nxt  = ack_n;
		irq_oe_n_nxt = 1'b0;
		if (pulse_style) begin
			// one-cycle low drive per event, then let go of the line
			irq_out_nxt  = 1'b0; // R8
			irq_oe_n_nxt = ~pp_irq_event; // R8
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_out_r  <= 1'b1;
			irq_oe_n_r <= 1'b1;
		end else begin
			irq_out_r  <= irq_out_nxt;
			irq_oe_n_r <= irq_oe_n_nxt;
		end
	end

	assign pp_irq_out  = irq_out_r;
	assign pp_irq_oe_n = irq_oe_n_r;

	// ----------------------------------------
	// epp timeout flag
	// ----------------------------------------
	logic tmo_r, tmo_nxt;
	logic tmo_clear;

	assign tmo_clear = pp_cfg.timeout_by_write ? epp_timeout_write_one // R14
	                                            : epp_status_read_done; // R13

	always_comb begin
		tmo_nxt = tmo_r;
		if (tmo_clear)
			tmo_nxt = 1'b0;
		// a new timeout in the clearing cycle is kept
		if (epp_timeout_set)
			tmo_nxt = 1'b1;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			tmo_r <= 1'b0;
		else
			tmo_r <= tmo_nxt;
	end

	assign epp_timeout = tmo_r;

endmodule

// ----------------------------------------
// one masked configuration register
// ----------------------------------------
module ldcr_cfg_reg #(
	parameter int               WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET = '0,
	parameter logic [WIDTH-1:0] WMASK = '1
) (
	// clock and hard reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// write request
	input  wire logic             we,
	input  wire logic [WIDTH-1:0] wdata,
	// stored value
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] val_r, val_nxt;

	always_comb begin
		val_nxt = val_r;
		// masked bits never store, so reads need no second mask
		if (we)
			val_nxt = wdata & WMASK; // R20
	end

	// rstn is the hard reset; soft resets do not reach this bank
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			val_r <= RESET; // R19
		else
			val_r <= val_nxt;
	end

	assign q = val_r;

endmodule

//--- sim/ldcr_config_bank_assertions.sv
// port checker of the logical device configuration bank, with its bind
`timescale 1ns/1ps
module ldcr_config_bank_checker (
	// clock and reset
	input wire logic                      clk,
	input wire logic                      rstn,
	// register port
	input wire logic [15:0]               addr,
	input wire logic [7:0]                wdata,
	input wire logic                      wr,
	input wire logic                      rd,
	input wire logic [7:0]                rdata,
	// decoded configuration
	input wire ldcr_pkg::ldcr_drive_cfg_s first_drive_options,
	input wire ldcr_pkg::ldcr_pp_cfg_s    pp_cfg,
	input wire logic [7:0]                port_config_b_readback,
	// interrupt pin and timeout flag
	input wire logic                      ack_n,
	input wire logic                      pp_irq_event,
	input wire logic                      pp_irq_out,
	input wire logic                      pp_irq_oe_n,
	input wire logic                      epp_timeout_set,
	input wire logic                      epp_status_read_done,
	input wire logic                      epp_timeout_write_one,
	input wire logic                      epp_timeout
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic basic;
	logic pulse_ev;
	// mode 110 counts as non-basic, so only these two ignore the type bit
	assign basic = pp_cfg.mode inside {3'b100, 3'b000};
	assign pulse_ev = pp_irq_event && pp_cfg.irq_pulsed && !basic;

	a_fdd_zero_bits: assert property (rd && addr == 16'h00f4 |=> (rdata & 8'ha4) == 8'h00)
		else $error("drive options read-only bits not zero");
	a_shadow_bit_six: assert property (rd && addr == 16'h03f1 |=> !rdata[6])
		else $error("shadow bit six not zero");
	a_readback_copy: assert property (port_config_b_readback == {2'b00, pp_cfg.irq_select, pp_cfg.dma_select})
		else $error("config-B readback wrong");
	a_irq_pulse_low: assert property (pulse_ev |=> !pp_irq_out && !pp_irq_oe_n)
		else $error("interrupt pulse missing");
	a_basic_follow: assert property (rstn && basic |=> pp_irq_out == $past(ack_n) && !pp_irq_oe_n)
		else $error("basic mode pin not following acknowledge");
	a_tmo_read_clear: assert property (!pp_cfg.timeout_by_write && epp_status_read_done && !epp_timeout_set |=> !epp_timeout)
		else $error("timeout not cleared by status read");
	a_tmo_write_hold: assert property (pp_cfg.timeout_by_write && epp_timeout && !epp_timeout_write_one |=> epp_timeout)
		else $error("timeout cleared without written one");
	a_precomp_off: assert property (wr && addr == 16'h00f4 |=> first_drive_options.precomp_enable == !$past(wdata[6]))
		else $error("precompensation enable wrong");

	c_pulse: cover property (pulse_ev);
	c_tmo_clear: cover property (epp_timeout ##1 !epp_timeout);
	c_shadow_wr: cover property (wr && addr == 16'h03f1);
endmodule

bind ldcr_config_bank ldcr_config_bank_checker chk (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .first_drive_options(first_drive_options), .pp_cfg(pp_cfg),
	.port_config_b_readback(port_config_b_readback), .ack_n(ack_n), .pp_irq_event(pp_irq_event),
	.pp_irq_out(pp_irq_out), .pp_irq_oe_n(pp_irq_oe_n), .epp_timeout_set(epp_timeout_set),
	.epp_status_read_done(epp_status_read_done), .epp_timeout_write_one(epp_timeout_write_one),
	.epp_timeout(epp_timeout));

//--- sim/ldcr_config_bank_tb_top.sv
// self-checking bench of the logical device configuration bank
`timescale 1ns/1ps
module ldcr_config_bank_tb_top;
	logic                      clk, rstn, wr, rd, ack_n, irq_out, irq_oe_n, tmo;
	logic [3:0]                pls;
	logic [15:0]               addr;
	logic [7:0]                wdata, rdata, cfgb;
	ldcr_pkg::ldcr_drive_cfg_s d0, d1;
	ldcr_pkg::ldcr_pp_cfg_s    pp;
	ldcr_pkg::ldcr_sp1_cfg_s   sp;
	int                        n_mismatch = 0;
	int                        n_tests = 0;

	ldcr_config_bank uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.first_drive_options(d0), .second_drive_options(d1), .pp_cfg(pp), .sp1_cfg(sp),
		.port_config_b_readback(cfgb), .ack_n(ack_n), .pp_irq_event(pls[0]), .pp_irq_out(irq_out),
		.pp_irq_oe_n(irq_oe_n), .epp_timeout_set(pls[1]), .epp_status_read_done(pls[2]),
		.epp_timeout_write_one(pls[3]), .epp_timeout(tmo));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	// one-cycle strobe on event, set, read-done or write-one
	task automatic pulse(input int i);
		@(posedge clk);
		pls[i] <= 1'b1;
		@(posedge clk);
		pls <= 4'h0;
		#1;
	endtask
	task automatic follow();
		@(posedge clk);
		ack_n <= 1'b0;
		@(posedge clk);
		#1;
		chk({6'h00, irq_oe_n, irq_out}, 8'h00);
		@(posedge clk);
		ack_n <= 1'b1;
		@(posedge clk);
		#1;
		chk({6'h00, irq_oe_n, irq_out}, 8'h01);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_defaults();
		rd_reg(16'h00f4, 8'h00);
		rd_reg(16'h00f5, 8'h00);
		rd_reg(16'h03f0, 8'h3c);
		rd_reg(16'h03f1, 8'h00);
		rd_reg(16'h04f0, 8'h00);
		rd_reg(16'h0055, 8'h00);
	endtask
	task automatic t_fdd();
		wr_reg(16'h00f4, 8'hff);
		rd_reg(16'h00f4, 8'h5b);
		chk({3'b000, d0}, 8'h1e);
		wr_reg(16'h00f5, 8'h10);
		rd_reg(16'h00f5, 8'h10);
		chk({3'b000, d1}, 8'h05);
		chk({3'b000, d0}, 8'h1e);
	endtask
	task automatic t_pp();
		for (int m = 0; m < 8; m++) begin
			wr_reg(16'h03f0, {5'h07, m[2:0]});
			chk({5'h00, pp.mode}, 8'(m));
		end
		chk({4'h0, pp.fifo_threshold}, 8'h07);
		for (int i = 0; i < 8; i++) begin
			wr_reg(16'h03f1, {2'b11, i[2:0], 1'b0, i[1:0]});
			rd_reg(16'h03f1, {2'b10, i[2:0], 1'b0, i[1:0]});
			chk(cfgb, {2'b00, i[2:0], 1'b0, i[1:0]});
			chk({5'h00, pp.irq_select}, 8'(i));
			chk({5'h00, pp.dma_select}, 8'(i % 4));
		end
	endtask
	task automatic t_irq();
		wr_reg(16'h03f0, 8'h8d);
		pulse(0);
		chk({6'h00, irq_oe_n, irq_out}, 8'h00);
		@(posedge clk);
		#1;
		chk({7'h00, irq_oe_n}, 8'h01);
		wr_reg(16'h03f0, 8'hbc);
		pulse(0);
		chk({6'h00, irq_oe_n, irq_out}, 8'h01);
		follow();
		wr_reg(16'h03f0, 8'h39);
		follow();
	endtask
	task automatic t_tmo();
		wr_reg(16'h03f1, 8'h00);
		pulse(1);
		pulse(3);
		chk({7'h00, tmo}, 8'h01);
		pulse(2);
		chk({7'h00, tmo}, 8'h00);
		wr_reg(16'h03f1, 8'h80);
		chk(cfgb, 8'h00);
		pulse(1);
		pulse(2);
		chk({7'h00, tmo}, 8'h01);
		pulse(3);
		chk({7'h00, tmo}, 8'h00);
		// set and written one in one cycle: the set is kept
		@(posedge clk);
		pls <= 4'ha;
		@(posedge clk);
		pls <= 4'h0;
		#1;
		chk({7'h00, tmo}, 8'h01);
	endtask
	task automatic t_serial();
		wr_reg(16'h04f0, 8'h01);
		rd_reg(16'h04f0, 8'h01);
		chk({6'h00, sp}, 8'h02);
		wr_reg(16'h04f0, 8'h82);
		rd_reg(16'h04f0, 8'h02);
		chk({6'h00, sp}, 8'h01);
		rd_reg(16'h03f0, 8'h39);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		{rstn, wr, rd, pls} = '0;
		ack_n = 1'b1;
		addr = 16'h0000;
		wdata = 8'h00;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		t_defaults();
		t_fdd();
		t_pp();
		t_irq();
		t_tmo();
		t_serial();
		// hard reset in mid-run brings every default back
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_defaults();
		close_out();
	end

	initial begin
		#200000;
		n_mismatch++;
		close_out();
	end
endmodule
